// ==== lpx_defs.svh ====
// Exchange limit and encoding constants for the link parameter exchange negotiator.
`ifndef LPX_DEFS_SVH
`define LPX_DEFS_SVH
`define LPX_MAX_EXCH      2'h2
`define LPX_MSG_W         3
`define LPX_MSG_NONE      3'h0
`define LPX_MSG_REQ       3'h1
`define LPX_MSG_ACC       3'h2
`define LPX_MSG_RJT       3'h3
`define LPX_MSG_ACK       3'h4
`endif

// ==== lpx_pkg.sv ====
// Types shared by both ends of the link parameter exchange.
`include "lpx_defs.svh"
package lpx_pkg;
	typedef logic [`LPX_MSG_W-1:0] lpx_msg_t;
	typedef enum logic {LPX_ROLE_RESP, LPX_ROLE_ORIG} lpx_role_t;
endpackage

// ==== lpx_link_if.sv ====
// Link between two exchange ports: one message strobe each way.
`timescale 1ns/10ps
interface lpx_link_if;
	logic                tx_vld_a;
	lpx_pkg::lpx_msg_t   tx_msg_a;
	logic                tx_vld_b;
	lpx_pkg::lpx_msg_t   tx_msg_b;
	modport dev_mp  (output tx_vld_a, output tx_msg_a, input tx_vld_b, input tx_msg_b);
	modport peer_mp (output tx_vld_b, output tx_msg_b, input tx_vld_a, input tx_msg_a);
endinterface

// ==== lpx_port.sv ====
// Exchange negotiator core, used at both ends of the link.
//
// How it works
// - originator succeeds after sending ACK to accept.
// - originator fails and isolates after ACK to reject.
// - responder succeeds on ACK to its accept.
// - responder fails and isolates on ACK to reject.
// - negotiation always ends in accept or reject.
// - rejecting responder may retry as originator.
// - rejected originator ACKs, becomes responder, isolated.
// - new responder accepts, then awaits ACK.
// - new responder rejects, awaits ACK, isolates.
// - at most two exchanges, then operational or isolated.
`timescale 1ns/10ps
`include "lpx_defs.svh"
module lpx_port (
	// Clock and reset.
	input  wire logic                clk_i,
	input  wire logic                nrst_i,
	// User side.
	input  wire logic                start_i,
	input  wire logic                accept_i,
	input  wire logic                retry_i,
	output logic                     role_o,
	output logic                     done_o,
	output logic                     oper_o,
	output logic                     isol_o,
	// Link side.
	output logic                     tx_vld_o,
	output lpx_pkg::lpx_msg_t        tx_msg_o,
	input  wire logic                rx_vld_i,
	input  wire lpx_pkg::lpx_msg_t   rx_msg_i
);
	import lpx_pkg::*;

	typedef enum logic [2:0] {LPX_IDLE, LPX_WREPLY, LPX_WACK, LPX_WRETRY, LPX_WREQ, LPX_END} lpx_state_t;

	lpx_state_t  state_reg;
	lpx_state_t  state_next;
	lpx_role_t   role_reg;
	logic [1:0]  exch_reg;
	logic        acc_sent_reg;
	logic        tx_vld_reg;
	lpx_msg_t    tx_msg_reg;
	logic        done_reg;
	logic        oper_reg;
	logic        isol_reg;

	////////////////////////////////////////////////////////////////////////////
	wire rx_req  = rx_vld_i && (rx_msg_i == `LPX_MSG_REQ);
	wire rx_acc  = rx_vld_i && (rx_msg_i == `LPX_MSG_ACC);
	wire rx_rjt  = rx_vld_i && (rx_msg_i == `LPX_MSG_RJT);
	wire rx_ack  = rx_vld_i && (rx_msg_i == `LPX_MSG_ACK);
	wire can_go  = exch_reg < `LPX_MAX_EXCH;

	// Next state; the message sent follows from the same decision.
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			LPX_IDLE: begin
				if (start_i && can_go)
					state_next = LPX_WREPLY;
				else if (rx_req && can_go)
					state_next = LPX_WACK;
			end
			LPX_WREPLY: begin
				if (rx_acc)
					state_next = LPX_END;
				else if (rx_rjt)
					state_next = can_go ? LPX_WREQ : LPX_END;
			end
			LPX_WACK: begin
				if (rx_ack)
					state_next = (acc_sent_reg || !can_go) ? LPX_END : LPX_WRETRY;
			end
			LPX_WRETRY: begin
				if (retry_i)
					state_next = LPX_WREPLY;
				else if (start_i)
					state_next = LPX_END;
			end
			LPX_WREQ: begin
				if (rx_req)
					state_next = LPX_WACK;
			end
			LPX_END: state_next = LPX_END;
		endcase
	end

	wire sent_req  = (state_next == LPX_WREPLY) && (state_reg != LPX_WREPLY);
	wire sent_rep  = (state_next == LPX_WACK) && (state_reg != LPX_WACK);
	wire sent_ack  = (state_reg == LPX_WREPLY) && (rx_acc || rx_rjt);
	wire fin       = (state_next == LPX_END) && (state_reg != LPX_END);
	wire fin_ok    = fin && ((state_reg == LPX_WREPLY && rx_acc) || (state_reg == LPX_WACK && acc_sent_reg));
	// A rejected originator hands over the originator role as soon as it acks.
	wire enter_wait = (state_next == LPX_WREQ) && (state_reg != LPX_WREQ);

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_reg    <= LPX_IDLE;
			role_reg     <= LPX_ROLE_RESP;
			exch_reg     <= 2'h0;
			acc_sent_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (enter_wait)
				role_reg <= LPX_ROLE_RESP;
			if (sent_req) begin
				role_reg <= LPX_ROLE_ORIG;
				exch_reg <= exch_reg + 2'h1;
			end
			if (sent_rep) begin
				role_reg     <= LPX_ROLE_RESP;
				exch_reg     <= exch_reg + 2'h1;
				acc_sent_reg <= accept_i;
			end
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tx_vld_reg <= 1'b0;
			tx_msg_reg <= `LPX_MSG_NONE;
		end else begin
			tx_vld_reg <= sent_req || sent_rep || sent_ack;
			if (sent_req)
				tx_msg_reg <= `LPX_MSG_REQ;
			else if (sent_rep)
				tx_msg_reg <= accept_i ? `LPX_MSG_ACC : `LPX_MSG_RJT;
			else if (sent_ack)
				tx_msg_reg <= `LPX_MSG_ACK;
			else
				tx_msg_reg <= `LPX_MSG_NONE;
		end
	end

	// Outcome flags; the port is isolated while waiting out a rejection.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			done_reg <= 1'b0;
			oper_reg <= 1'b0;
			isol_reg <= 1'b0;
		end else begin
			if (fin) begin
				done_reg <= 1'b1;
				oper_reg <= fin_ok;
				isol_reg <= !fin_ok;
			end else if (state_next == LPX_WREQ || state_next == LPX_WRETRY) begin
				isol_reg <= 1'b1;
			end else if (state_next != LPX_END) begin
				isol_reg <= 1'b0;
			end
		end
	end

	assign role_o   = role_reg;
	assign done_o   = done_reg;
	assign oper_o   = oper_reg;
	assign isol_o   = isol_reg;
	assign tx_vld_o = tx_vld_reg;
	assign tx_msg_o = tx_msg_reg;
endmodule // lpx_port

// ==== lpx_dev_end.sv ====
// Device end: the negotiator core on the A side of the link.
`timescale 1ns/10ps
module lpx_dev_end (
	// Clock and reset.
	input  wire logic  clk_i,
	input  wire logic  nrst_i,
	// User side.
	input  wire logic  start_i,
	input  wire logic  accept_i,
	input  wire logic  retry_i,
	output logic       role_o,
	output logic       done_o,
	output logic       oper_o,
	output logic       isol_o,
	// Link side.
	lpx_link_if.dev_mp link
);
	lpx_port u_port (
		.clk_i    (clk_i),
		.nrst_i   (nrst_i),
		.start_i  (start_i),
		.accept_i (accept_i),
		.retry_i  (retry_i),
		.role_o   (role_o),
		.done_o   (done_o),
		.oper_o   (oper_o),
		.isol_o   (isol_o),
		.tx_vld_o (link.tx_vld_a),
		.tx_msg_o (link.tx_msg_a),
		.rx_vld_i (link.tx_vld_b),
		.rx_msg_i (link.tx_msg_b)
	);
endmodule // lpx_dev_end

// ==== lpx_peer_end.sv ====
// Peer end: the negotiator core on the B side of the link.
`timescale 1ns/10ps
module lpx_peer_end (
	// Clock and reset.
	input  wire logic  clk_i,
	input  wire logic  nrst_i,
	// User side.
	input  wire logic  start_i,
	input  wire logic  accept_i,
	input  wire logic  retry_i,
	output logic       role_o,
	output logic       done_o,
	output logic       oper_o,
	output logic       isol_o,
	// Link side.
	lpx_link_if.peer_mp link
);
	lpx_port u_port (
		.clk_i    (clk_i),
		.nrst_i   (nrst_i),
		.start_i  (start_i),
		.accept_i (accept_i),
		.retry_i  (retry_i),
		.role_o   (role_o),
		.done_o   (done_o),
		.oper_o   (oper_o),
		.isol_o   (isol_o),
		.tx_vld_o (link.tx_vld_b),
		.tx_msg_o (link.tx_msg_b),
		.rx_vld_i (link.tx_vld_a),
		.rx_msg_i (link.tx_msg_a)
	);
endmodule // lpx_peer_end

// ==== lpx_link_checker.sv ====
// Concurrent checks on the link between the two exchange ends.
`timescale 1ns/10ps
`include "lpx_defs.svh"
module lpx_link_checker (
	// Clock and reset.
	input wire logic              clk_i,
	input wire logic              nrst_i,
	// Link.
	input wire logic              tx_vld_a,
	input wire lpx_pkg::lpx_msg_t tx_msg_a,
	input wire logic              tx_vld_b,
	input wire lpx_pkg::lpx_msg_t tx_msg_b
);
	import lpx_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	// Bit 1 request, 2 accept, 3 reject, 4 ack; a bad code sets none of them.
	wire [4:0]  ea = tx_vld_a ? (5'h01 << tx_msg_a) : 5'h00;
	wire [4:0]  eb = tx_vld_b ? (5'h01 << tx_msg_b) : 5'h00;
	logic [2:0] nreq_reg;
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) nreq_reg <= 3'h0;
		else nreq_reg <= nreq_reg + {2'h0, ea[1]} + {2'h0, eb[1]};
	end
	property p_req_a; ea[1] |=> eb[2] || eb[3]; endproperty
	a_req_a: assert property (p_req_a) else $error("request from A not answered");
	property p_req_b; eb[1] |=> ea[2] || ea[3]; endproperty
	a_req_b: assert property (p_req_b) else $error("request from B not answered");
	property p_acc_a; ea[2] |=> eb[4]; endproperty
	a_acc_a: assert property (p_acc_a) else $error("accept from A not acked");
	property p_acc_b; eb[2] |=> ea[4]; endproperty
	a_acc_b: assert property (p_acc_b) else $error("accept from B not acked");
	property p_rjt_a; ea[3] |=> eb[4]; endproperty
	a_rjt_a: assert property (p_rjt_a) else $error("reject from A not acked");
	property p_rjt_b; eb[3] |=> ea[4]; endproperty
	a_rjt_b: assert property (p_rjt_b) else $error("reject from B not acked");
	property p_code; (!tx_vld_a || ea[4:1] != 4'h0) && (!tx_vld_b || eb[4:1] != 4'h0); endproperty
	a_code: assert property (p_code) else $error("bad message code");
	property p_lim; nreq_reg <= {1'h0, `LPX_MAX_EXCH}; endproperty
	a_lim: assert property (p_lim) else $error("too many requests");
endmodule // lpx_link_checker

// ==== tb_top.sv ====
// Self-checking bench: both exchange ends joined by one link.
`timescale 1ns/10ps
module tb_top;
	logic       clk_i;
	logic       nrst_i;
	logic [2:0] ua;
	logic [2:0] ub;
	logic [3:0] sa;
	logic [3:0] sb;
	int         fail_count;
	int         n_compared;
	int         cyc;
	lpx_link_if lnk ();
	lpx_dev_end i_lpx_dev_end (.clk_i(clk_i), .nrst_i(nrst_i), .start_i(ua[2]), .accept_i(ua[1]), .retry_i(ua[0]),
		.role_o(sa[3]), .done_o(sa[2]), .oper_o(sa[1]), .isol_o(sa[0]), .link(lnk.dev_mp));
	lpx_peer_end i_lpx_peer_end (.clk_i(clk_i), .nrst_i(nrst_i), .start_i(ub[2]), .accept_i(ub[1]), .retry_i(ub[0]),
		.role_o(sb[3]), .done_o(sb[2]), .oper_o(sb[1]), .isol_o(sb[0]), .link(lnk.peer_mp));
	lpx_link_checker i_lpx_link_checker (.clk_i(clk_i), .nrst_i(nrst_i), .tx_vld_a(lnk.tx_vld_a),
		.tx_msg_a(lnk.tx_msg_a), .tx_vld_b(lnk.tx_vld_b), .tx_msg_b(lnk.tx_msg_b));
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task give_verdict;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Cfg is {B accepts, B retries, B gives up, A accepts}; A always opens.
	task neg(input logic [3:0] cfg, input logic [7:0] exp);
		@(posedge clk_i);
		nrst_i <= 1'b0;
		ua <= 3'h0;
		ub <= {1'b0, cfg[3], cfg[2]};
		repeat (5) @(posedge clk_i);
		nrst_i <= 1'b1;
		ua <= {1'b1, cfg[0], 1'b0};
		@(posedge clk_i);
		ua[2] <= 1'b0;
		repeat (6) @(posedge clk_i);
		ub[2] <= cfg[1];
		repeat (8) @(posedge clk_i);
		#1;
		check("role done oper isol of A and B", {sa, sb}, exp);
		$display("test %h done", cfg);
	endtask
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 200) begin
			fail_count++;
			give_verdict();
		end
	end
	initial begin
		nrst_i = 1'b0;
		ua = 3'h0;
		ub = 3'h0;
		cyc = 0;
		fail_count = 0;
		n_compared = 0;
		neg(4'h8, 8'hE6);
		neg(4'h5, 8'h6E);
		neg(4'h4, 8'h5D);
		neg(4'h2, 8'h15);
		give_verdict();
	end
endmodule // tb_top
